// [rtl/clk_presc_pkg.sv]
package clk_presc_pkg;
   // ==================================================
   // register map, byte addresses on apb
   localparam logic [7:0] addr_change_protect = 8'h00;
   localparam logic [7:0] addr_clock_divide = 8'h04;
   localparam logic [7:0] addr_fast_trim = 8'h08;
   localparam logic [7:0] addr_temp_trim_a = 8'h0c;
   localparam logic [7:0] addr_temp_trim_b = 8'h10;
   localparam logic [7:0] addr_slow_trim = 8'h14;
   localparam logic [7:0] addr_status = 8'h18;
   // ==================================================
   // fields and values
   localparam int divide_select_lsb = 0;
   localparam int divide_select_width = 4;
   localparam logic [3:0] div_code_max = 4'h8;
   localparam logic [3:0] div_code_one = 4'h0;
   localparam logic [3:0] div_code_eight = 4'h3;
   localparam logic [7:0] unlock_signature = 8'hd8;
   localparam logic [7:0] fast_trim_factory = 8'h80;
   localparam logic [7:0] slow_trim_factory = 8'h80;
   localparam logic [7:0] temp_trim_reset = 8'h00;
   // ==================================================
   // timing: window of four cpu cycles counted in divided clock ticks
   localparam int unlock_window_cycles = 4;
   // ==================================================
   // states of the divider switch
   typedef enum logic [1:0] {
      sw_idle = 2'b00,
      sw_wait_old = 2'b01,
      sw_wait_new = 2'b11
   } switch_state_t;
endpackage

// [rtl/unlock_window.sv]
`timescale 1ns/1ps
`default_nettype none
module unlock_window
   import clk_presc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // cpu cycle pulse and unlock write
   input wire logic cpu_tick,
   input wire logic unlock_write,
   input wire logic consume,
   // window open
   output logic window_open
);
   logic [2:0] count;
   logic [2:0] next_count;
   // ==================================================
   // window counter, reopened by a fresh signature
   always_comb begin
      next_count = count;
      if (unlock_write) begin
         next_count = 3'(unlock_window_cycles);
      end else if (consume) begin
         next_count = 3'h0;
      end else if (cpu_tick && count != 3'h0) begin
         next_count = count - 3'h1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 3'h0;
      end else begin
         count <= next_count;
      end
   end
   assign window_open = (count != 3'h0);
   property p_window_closes;
      @(posedge pclk) disable iff (!presetn)
      (count == 3'h1 && cpu_tick && !unlock_write) |=> !window_open;
   endproperty
   a_window_closes: assert property (p_window_closes) else $error("window stays open");
endmodule // unlock_window
`default_nettype wire

// [rtl/clock_divider.sv]
`timescale 1ns/1ps
`default_nettype none
module clock_divider
   import clk_presc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // selected code
   input wire logic [3:0] divide_select,
   // enable pulse, one pclk per divided period
   output logic tick
);
   logic [7:0] count;
   logic [7:0] next_count;
   function automatic logic [7:0] div_limit(input logic [3:0] code);
      div_limit = 8'((9'h1 << code) - 9'h1);
   endfunction
   // ==================================================
   // counter only wraps at a terminal count, so a new ratio takes effect
   // after the old period ends: no short pulse, no glitch
   always_comb begin
      next_count = count + 8'h1;
      if (count >= div_limit(divide_select)) begin
         next_count = 8'h0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 8'h0;
      end else begin
         count <= next_count;
      end
   end
   assign tick = (count >= div_limit(divide_select));
   property p_tick_spacing;
      @(posedge pclk) disable iff (!presetn)
      (tick && divide_select == 4'h1) ##1 (divide_select == 4'h1) |-> !tick;
   endproperty
   a_tick_spacing: assert property (p_tick_spacing) else $error("ticks too close");
endmodule // clock_divider
`default_nettype wire

// [rtl/clock_prescaler_and_osc_trim.sv]
`timescale 1ns/1ps
`default_nettype none
module clock_prescaler_and_osc_trim
   import clk_presc_pkg::*;
#(
   parameter logic [7:0] fast_factory = clk_presc_pkg::fast_trim_factory,
   parameter logic [7:0] slow_factory = clk_presc_pkg::slow_trim_factory
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // fuse, a static strap
   input wire logic start_divide_fuse,
   // divided system clock enable
   output logic sys_clk_en,
   // oscillator trim outputs
   output logic [7:0] fast_trim_value,
   output logic [7:0] temp_trim_a,
   output logic [7:0] temp_trim_b,
   output logic [7:0] slow_trim_value,
   // nonvolatile write timing follows the fast oscillator
   output logic [7:0] nvm_timing_trim
);
   // ==================================================
   // declarations
   logic [3:0] divide_select;
   logic [3:0] next_divide_select;
   logic [3:0] active_select;
   logic [3:0] next_active_select;
   logic [7:0] next_fast_trim;
   logic [7:0] next_temp_a;
   logic [7:0] next_temp_b;
   logic [7:0] next_slow_trim;
   logic [31:0] next_prdata;
   logic fuse_sync1;
   logic fuse_sync2;
   logic [1:0] fuse_age;
   logic fuse_loaded;
   logic next_fuse_loaded;
   logic rejected;
   logic next_rejected;
   switch_state_t sw_state;
   switch_state_t next_sw_state;
   logic window_open;
   logic wr_access;
   logic rd_access;
   logic unlock_write;
   logic divide_write;
   logic mapped;
   logic tick;
   function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
      hit = (a == reg_addr);
   endfunction
   function automatic logic [3:0] clamp_code(input logic [3:0] code);
      clamp_code = (code > div_code_max) ? div_code_max : code;
   endfunction
   // ==================================================
   // apb decode, zero wait states
   assign wr_access = psel && penable && pwrite;
   assign rd_access = psel && !penable && !pwrite;
   assign mapped = hit(paddr, addr_change_protect) || hit(paddr, addr_clock_divide)
      || hit(paddr, addr_fast_trim) || hit(paddr, addr_temp_trim_a)
      || hit(paddr, addr_temp_trim_b) || hit(paddr, addr_slow_trim)
      || hit(paddr, addr_status);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign unlock_write = wr_access && pstrb[0] && hit(paddr, addr_change_protect)
      && pwdata[7:0] == unlock_signature;
   assign divide_write = wr_access && pstrb[0] && hit(paddr, addr_clock_divide);
   // ==================================================
   // fuse strap synchroniser, caught once after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fuse_sync1 <= 1'b0;
         fuse_sync2 <= 1'b0;
         fuse_age <= 2'b00;
      end else begin
         fuse_sync1 <= start_divide_fuse;
         fuse_sync2 <= fuse_sync1;
         fuse_age <= {fuse_age[0], 1'b1};
      end
   end
   // ==================================================
   // register updates
   always_comb begin
      next_divide_select = divide_select;
      next_fast_trim = fast_trim_value;
      next_temp_a = temp_trim_a;
      next_temp_b = temp_trim_b;
      next_slow_trim = slow_trim_value;
      next_fuse_loaded = fuse_loaded;
      next_rejected = rejected;
      // strap taken only once both sync stages hold its real level
      if (!fuse_loaded && fuse_age[1]) begin
         next_fuse_loaded = 1'b1;
         next_divide_select = fuse_sync2 ? div_code_eight : div_code_one;
      end
      if (divide_write) begin
         if (window_open) begin
            next_divide_select = pwdata[3:0];
            next_rejected = 1'b0;
         end else begin
            next_rejected = 1'b1;
         end
      end
      if (wr_access && pstrb[0]) begin
         if (hit(paddr, addr_fast_trim)) begin
            next_fast_trim = pwdata[7:0];
         end
         if (hit(paddr, addr_temp_trim_a)) begin
            next_temp_a = pwdata[7:0];
         end
         if (hit(paddr, addr_temp_trim_b)) begin
            next_temp_b = pwdata[7:0];
         end
         if (hit(paddr, addr_slow_trim)) begin
            next_slow_trim = pwdata[7:0];
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         divide_select <= div_code_one;
         fast_trim_value <= fast_factory;
         temp_trim_a <= temp_trim_reset;
         temp_trim_b <= temp_trim_reset;
         slow_trim_value <= slow_factory;
         fuse_loaded <= 1'b0;
         rejected <= 1'b0;
      end else begin
         divide_select <= next_divide_select;
         fast_trim_value <= next_fast_trim;
         temp_trim_a <= next_temp_a;
         temp_trim_b <= next_temp_b;
         slow_trim_value <= next_slow_trim;
         fuse_loaded <= next_fuse_loaded;
         rejected <= next_rejected;
      end
   end
   // trim is monotonic by construction: fast trim passed straight to the nvm write timing output
   assign nvm_timing_trim = fast_trim_value;
   // ==================================================
   // divider switch: the new code reaches the divider only at an old-period
   // boundary, then one new period must pass before the switch is reported done
   always_comb begin
      next_sw_state = sw_state;
      next_active_select = active_select;
      case (sw_state)
         sw_idle: begin
            if (clamp_code(divide_select) != active_select) begin
               next_sw_state = sw_wait_old;
            end
         end
         sw_wait_old: begin
            if (tick) begin
               // reserved codes clamp to the largest ratio
               next_active_select = clamp_code(divide_select);
               next_sw_state = sw_wait_new;
            end
         end
         sw_wait_new: begin
            if (tick) begin
               next_sw_state = sw_idle;
            end
         end
         default: begin
            next_sw_state = sw_idle;
         end
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_state <= sw_idle;
         active_select <= div_code_one;
      end else begin
         sw_state <= next_sw_state;
         active_select <= next_active_select;
      end
   end
   clock_divider u_divider (
      .pclk(pclk),
      .presetn(presetn),
      .divide_select(active_select),
      .tick(tick)
   );
   assign sys_clk_en = tick;
   // window counted in divided cpu cycles
   unlock_window u_window (
      .pclk(pclk),
      .presetn(presetn),
      .cpu_tick(tick),
      .unlock_write(unlock_write),
      .consume(divide_write),
      .window_open(window_open)
   );
   // ==================================================
   // read data, captured in setup so it is registered
   always_comb begin
      next_prdata = prdata;
      if (rd_access) begin
         next_prdata = 32'h0;
         if (hit(paddr, addr_clock_divide)) begin
            next_prdata = {28'h0, divide_select};
         end
         if (hit(paddr, addr_fast_trim)) begin
            next_prdata = {24'h0, fast_trim_value};
         end
         if (hit(paddr, addr_temp_trim_a)) begin
            next_prdata = {24'h0, temp_trim_a};
         end
         if (hit(paddr, addr_temp_trim_b)) begin
            next_prdata = {24'h0, temp_trim_b};
         end
         if (hit(paddr, addr_slow_trim)) begin
            next_prdata = {24'h0, slow_trim_value};
         end
         if (hit(paddr, addr_status)) begin
            next_prdata = {24'h0, 1'b0, rejected, window_open, sw_state != sw_idle,
               active_select};
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else begin
         prdata <= next_prdata;
      end
   end
   // ==================================================
   // checks
   property p_locked_write;
      @(posedge pclk) disable iff (!presetn)
      (divide_write && !window_open && fuse_loaded) |=> $stable(divide_select);
   endproperty
   a_locked_write: assert property (p_locked_write) else $error("locked write took");
   property p_unlocked_write;
      @(posedge pclk) disable iff (!presetn)
      (divide_write && window_open && fuse_loaded) |=> divide_select == $past(pwdata[3:0]);
   endproperty
   a_unlocked_write: assert property (p_unlocked_write) else $error("write lost");
   property p_fuse_load;
      @(posedge pclk) disable iff (!presetn)
      (!fuse_loaded && fuse_age[1])
         |=> divide_select == ($past(fuse_sync2) ? div_code_eight : div_code_one);
   endproperty
   a_fuse_load: assert property (p_fuse_load) else $error("bad reset divide");
   property p_reserved_zero;
      @(posedge pclk) disable iff (!presetn)
      (rd_access && hit(paddr, addr_clock_divide)) |=> prdata[31:4] == 28'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");
   property p_switch_at_tick;
      @(posedge pclk) disable iff (!presetn)
      (active_select != $past(active_select)) |-> $past(tick);
   endproperty
   a_switch_at_tick: assert property (p_switch_at_tick) else $error("mid period switch");
   property p_trim_write;
      @(posedge pclk) disable iff (!presetn)
      (wr_access && pstrb[0] && hit(paddr, addr_fast_trim)) |=> fast_trim_value == $past(pwdata[7:0]);
   endproperty
   a_trim_write: assert property (p_trim_write) else $error("trim write lost");
   property p_slow_write;
      @(posedge pclk) disable iff (!presetn)
      (wr_access && pstrb[0] && hit(paddr, addr_slow_trim)) |=> slow_trim_value == $past(pwdata[7:0]);
   endproperty
   a_slow_write: assert property (p_slow_write) else $error("slow trim lost");
   property p_active_range;
      @(posedge pclk) disable iff (!presetn)
      active_select <= div_code_max;
   endproperty
   a_active_range: assert property (p_active_range) else $error("reserved ratio used");
endmodule // clock_prescaler_and_osc_trim
`default_nettype wire

// [testbench/clock_prescaler_and_osc_trim_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module clock_prescaler_and_osc_trim_tb;
   import clk_presc_pkg::*;
   // ==================================================
   // signals
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
   logic start_divide_fuse, sys_clk_en;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [3:0] pstrb;
   logic [7:0] fast_trim_value, temp_trim_a, temp_trim_b, slow_trim_value, nvm_timing_trim;
   logic [7:0] trim_addr [4];
   logic [7:0] trim_rst [4];
   logic [7:0] trim_out [4];
   int fails, cmp_count, cycles, old_p;
   assign trim_out[0] = fast_trim_value;
   assign trim_out[1] = temp_trim_a;
   assign trim_out[2] = temp_trim_b;
   assign trim_out[3] = slow_trim_value;
   clock_prescaler_and_osc_trim dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .start_divide_fuse(start_divide_fuse), .sys_clk_en(sys_clk_en),
      .fast_trim_value(fast_trim_value), .temp_trim_a(temp_trim_a),
      .temp_trim_b(temp_trim_b), .slow_trim_value(slow_trim_value),
      .nvm_timing_trim(nvm_timing_trim)
   );
   // ==================================================
   // clock and hang guard
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         $display("[ERR] %0t run took too long", $time);
         end_of_test();
      end
   end
   // ==================================================
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // entered right after a rising edge; psel stays up so calls can run back to back
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the global cycle guard ends a wait for pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdata = prdata;
      serr = pslverr;
   endtask
   task automatic idle();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      xfer(1'b0, a, 32'h0);
      chk(rdata, exp, what);
   endtask
   task automatic chg(input logic [31:0] code);
      xfer(1'b1, addr_change_protect, {24'h0, unlock_signature});
      xfer(1'b1, addr_clock_divide, code);
      idle();
   endtask
   task automatic do_reset(input logic fuse);
      start_divide_fuse <= fuse;
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask
   // skip the switch-over, bounding how late the second tick comes, then time one period
   task automatic measure(input int oldp, input int newp);
      int n, k;
      n = 0;
      k = 0;
      while (k < 3 && n < 4000) begin
         @(negedge pclk);
         n++;
         if (sys_clk_en === 1'b1) begin
            k++;
            if (k == 2) chk(n <= oldp + 2 * newp + 3, 1'b1, "switch slow");
         end
      end
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (sys_clk_en !== 1'b1 && n < 600);
      chk(n, newp, "period");
      @(posedge pclk);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ==================================================
   // main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hf;
      start_divide_fuse = 1'b0;
      fails = 0;
      cmp_count = 0;
      cycles = 0;
      trim_addr = '{addr_fast_trim, addr_temp_trim_a, addr_temp_trim_b, addr_slow_trim};
      trim_rst = '{fast_trim_factory, temp_trim_reset, temp_trim_reset, slow_trim_factory};
      do_reset(1'b0);
      rd_chk(addr_clock_divide, 32'h0, "divide reset");
      for (int i = 0; i < 4; i++) begin
         rd_chk(trim_addr[i], {24'h0, trim_rst[i]}, "trim reset");
      end
      // step of 0x10 keeps the fast trim change small and well under the memory-write ceiling
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, trim_addr[i], {24'hffffff, 8'h90 + 8'(i)});
      end
      idle();
      for (int i = 0; i < 4; i++) begin
         rd_chk(trim_addr[i], {24'h0, 8'h90 + 8'(i)}, "trim rw");
         chk(trim_out[i], 8'h90 + 8'(i), "trim out");
      end
      chk(nvm_timing_trim, 8'h90, "nvm timing");
      xfer(1'b0, 8'h1c, 32'h0);
      chk(serr, 1'b1, "unmapped err");
      chk(rdata, 32'h0, "unmapped data");
      idle();
      // unprotected write, then a write after the window has run out
      xfer(1'b1, addr_clock_divide, 32'h5);
      idle();
      rd_chk(addr_clock_divide, 32'h0, "no unlock");
      xfer(1'b0, addr_status, 32'h0);
      chk(rdata[6], 1'b1, "reject flag");
      xfer(1'b1, addr_change_protect, {24'h0, unlock_signature});
      xfer(1'b0, addr_status, 32'h0);
      chk(rdata[5], 1'b1, "window open");
      idle();
      repeat (8) @(posedge pclk);
      xfer(1'b1, addr_clock_divide, 32'h5);
      idle();
      rd_chk(addr_clock_divide, 32'h0, "late write");
      idle();
      measure(1, 1);
      old_p = 1;
      for (int c = 1; c <= 8; c++) begin
         chg(c);
         measure(old_p, 1 << c);
         rd_chk(addr_clock_divide, c, "divide rw");
         old_p = 1 << c;
      end
      chg(32'h0);
      measure(256, 1);
      chg(32'h9);
      rd_chk(addr_clock_divide, 32'h9, "reserved code");
      chg(32'hff);
      rd_chk(addr_clock_divide, 32'h0f, "upper bits");
      idle();
      // second reset in mid-run with the fuse programmed
      do_reset(1'b1);
      rd_chk(addr_clock_divide, {28'h0, div_code_eight}, "fuse reset");
      idle();
      measure(8, 8);
      chg(32'h0);
      rd_chk(addr_clock_divide, 32'h0, "fuse override");
      idle();
      measure(8, 1);
      end_of_test();
   end
endmodule // clock_prescaler_and_osc_trim_tb
`default_nettype wire
